// >>> tbc_chan.v
`timescale 1ns/100ps
`default_nettype none
module tbc_chan
(
  // Clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_n_i,
  // Control
  input  wire       built_in_selftest_en_i,
  input  wire       built_in_selftest_sync_i,
  input  wire       sync_start_i,
  input  wire       atomic_i,
  input  wire [1:0] type_i,
  input  wire [7:0] data_i,
  input  wire [1:0] ctrl_i,
  // Output character
  output reg  [7:0] char_o,
  output reg  [1:0] type_o,
  output reg        built_in_selftest_act_o,
  output reg        sync_act_o
);
`include "tbc_map.vh"
  reg [8:0] linear_feedback_shifter_q;
  reg [8:0] bcnt_q;
  reg [4:0] scnt_q;
  reg       bpre_q;
  wire      sync_busy = (scnt_q != 5'h0);
  wire      char_end  = (scnt_q == 5'h1);
  // =====================================================
  // Self-test generator and word sync
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      linear_feedback_shifter_q     <= `TBC_LINEAR_FEEDBACK_SHIFTER_SEED;
      bcnt_q     <= 9'h0;
      scnt_q     <= 5'h0;
      bpre_q     <= 1'b0;
      built_in_selftest_act_o <= 1'b0;
      sync_act_o <= 1'b0;
      char_o     <= 8'h0;
      type_o     <= `TBC_TYPE_DATA;
    end
    else
    begin
      // Enable taken only outside a word sync sequence, no partial sync output
      if (built_in_selftest_act_o != built_in_selftest_en_i && !sync_busy)
      begin
        built_in_selftest_act_o <= built_in_selftest_en_i;
        linear_feedback_shifter_q     <= `TBC_LINEAR_FEEDBACK_SHIFTER_SEED;
        bcnt_q     <= 9'h0;
        bpre_q     <= built_in_selftest_en_i & built_in_selftest_sync_i;
        // Neutral character, no stale host type leaks into self-test
        char_o     <= 8'h0;
        type_o     <= `TBC_TYPE_DATA;
      end
      else if (built_in_selftest_act_o)
      begin
        // Host inputs unused here
        if (bpre_q && scnt_q == 5'h0)
        begin
          scnt_q     <= `TBC_SYNC_LEN;
          type_o     <= `TBC_TYPE_SYNC;
          sync_act_o <= 1'b1;
          bpre_q     <= 1'b0;
        end
        else if (sync_busy)
        begin
          scnt_q     <= scnt_q - 5'h1;
          sync_act_o <= !char_end;
        end
        else
        begin
          linear_feedback_shifter_q <= {linear_feedback_shifter_q[7:0], linear_feedback_shifter_q[8] ^ linear_feedback_shifter_q[4]};
          char_o <= linear_feedback_shifter_q[7:0];
          type_o <= linear_feedback_shifter_q[8] ? `TBC_TYPE_SPECIAL : `TBC_TYPE_DATA;
          if (bcnt_q == `TBC_BUILT_IN_SELFTEST_LEN - 9'h1)
          begin
            bcnt_q <= 9'h0;
            linear_feedback_shifter_q <= `TBC_LINEAR_FEEDBACK_SHIFTER_SEED;
            bpre_q <= built_in_selftest_sync_i;
          end
          else
            bcnt_q <= bcnt_q + 9'h1;
        end
      end
      else if (sync_busy && atomic_i)
      begin
        // Atomic sequence ignores input registers
        scnt_q     <= scnt_q - 5'h1;
        sync_act_o <= !char_end;
        if (char_end && sync_start_i)
        begin
          scnt_q     <= `TBC_SYNC_LEN;
          sync_act_o <= 1'b1;
        end
      end
      else if (sync_busy && ctrl_i == 2'h0)
      begin
        scnt_q <= scnt_q - 5'h1;
        sync_act_o <= !char_end;
      end
      else
      begin
        char_o <= data_i;
        type_o <= type_i;
        if (sync_start_i)
        begin
          scnt_q     <= `TBC_SYNC_LEN;
          sync_act_o <= 1'b1;
        end
        else
        begin
          // Interrupted sequence is dropped, counter cleared to zero
          scnt_q     <= 5'h0;
          sync_act_o <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tbc_host.sv
`timescale 1ns/100ps
`default_nettype none
// ==============================
// Host driving parallel characters
module tbc_host
(
  input  wire logic        sys_clk_i,
  input  wire logic [7:0]  ctl_i,
  input  wire logic [31:0] dat_i,
  output var  logic [7:0]  ctl_o,
  output var  logic [31:0] dat_o
);
  initial
  begin
    ctl_o = 8'h00;
    dat_o = 32'h0;
  end
  // Falling edge keeps clear of the sampling edge
  always @(negedge sys_clk_i)
  begin
    ctl_o <= ctl_i;
    dat_o <= dat_i;
  end
endmodule
`default_nettype wire

// >>> tbc_map.vh
`ifndef TBC_MAP_VH
`define TBC_MAP_VH
// =====================================================
// Character types
`define TBC_TYPE_DATA      2'h0
`define TBC_TYPE_FILL      2'h1
`define TBC_TYPE_SPECIAL   2'h2
`define TBC_TYPE_SYNC      2'h3
// =====================================================
// Bonding select encodings
`define TBC_BOND_NONE      2'h0
`define TBC_BOND_DUAL      2'h1
`define TBC_BOND_QUAD      2'h2
// =====================================================
// Self-test sequence figures
`define TBC_BUILT_IN_SELFTEST_LEN       9'h1ff
`define TBC_SYNC_LEN       5'h10
`define TBC_LINEAR_FEEDBACK_SHIFTER_SEED      9'h1ff
// =====================================================
// Reset values
`define TBC_LATCH_RST      8'hff
`endif

// >>> tbc_props_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ==============================
// Checker on the top ports
module tbc_props
#(
  parameter NCH = 4
)
(
  // Clock and reset
  input wire logic             sys_clk_i,
  input wire logic             rst_n_i,
  // Pins
  input wire logic [7:0]       per_output_enable_bits_i,
  input wire logic             selftest_latch_enable_i,
  input wire logic             rx_clock_source_select_mid_i,
  input wire logic             tx_operating_select_hi_low_i,
  input wire logic             tx_atomic_sync_i,
  input wire logic [1:0]       rx_bonding_select_i,
  // Host characters
  input wire logic [NCH*8-1:0] tx_char_data_i,
  input wire logic [NCH*2-1:0] tx_char_control_i,
  // Outputs
  input wire logic [NCH*8-1:0] char_o,
  input wire logic [NCH*2-1:0] type_o,
  input wire logic [NCH-1:0]   built_in_selftest_act_o,
  input wire logic [NCH-1:0]   sync_act_o,
  input wire logic [7:0]       selftest_latch_o
);
  wire logic [7:0] c;
  wire logic [1:0] bs;
  wire logic       idle;
  assign c = tx_char_control_i[7:0];
  assign bs = rx_bonding_select_i;
  assign idle = built_in_selftest_act_o == 4'h0;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Eight sync characters in a row
  sequence s_half;
    (sync_act_o[0] && type_o[1:0] == 2'h3) [*8];
  endsequence
  a_reset_latch: assert property ($rose(rst_n_i) |-> selftest_latch_o == 8'hff)
    else $error("latch not preset");
  a_built_in_selftest_enable: assert property ($rose(built_in_selftest_act_o[0]) |-> !selftest_latch_o[1])
    else $error("self-test without enable");
  a_sync_len: assert property ($rose(sync_act_o[0]) && tx_atomic_sync_i |-> s_half ##1 s_half)
    else $error("word sync short");
  a_sync_start: assert property (bs == 2'h0 && c[1:0] == 2'h3 && idle
    |-> ##2 sync_act_o[0]) else $error("sync not started");
  a_dual_ab: assert property (bs == 2'h1 && c[2] && idle
    |-> ##2 sync_act_o[1:0] == 2'h3) else $error("dual sync a b");
  a_dual_cd: assert property (bs == 2'h1 && c[6] && idle
    |-> ##2 sync_act_o[3:2] == 2'h3) else $error("dual sync c d");
  a_quad_all: assert property (bs == 2'h2 && c[2] && idle
    |-> ##2 sync_act_o == 4'hf) else $error("quad sync");
  a_quad_data: assert property (bs == 2'h2 && c[2:0] == 3'h0 && idle
    && sync_act_o == 4'h0 |-> ##2 (sync_act_o[0] || (type_o[1:0] == 2'h0
    && char_o[7:0] == $past(tx_char_data_i[7:0], 2))))
    else $error("quad data");
  a_built_in_selftest_deaf: assert property (built_in_selftest_act_o[0] && !sync_act_o[0]
    |-> type_o[1:0] != 2'h1) else $error("host char in self-test");
endmodule
bind tbc_top tbc_props #(.NCH(NCH)) u_props (.*);
`default_nettype wire

// >>> tbc_top.v
`timescale 1ns/100ps
`default_nettype none
module tbc_top
#(
  parameter NCH = 4
)
(
  // Clock and reset
  input  wire             sys_clk_i,
  input  wire             rst_n_i,
  // Pins from outside the clock domain
  input  wire [7:0]       per_output_enable_bits_i,
  input  wire             selftest_latch_enable_i,
  input  wire             rx_clock_source_select_mid_i,
  input  wire             tx_operating_select_hi_low_i,
  input  wire             tx_atomic_sync_i,
  input  wire [1:0]       rx_bonding_select_i,
  // Host characters, same clock
  input  wire [NCH*8-1:0] tx_char_data_i,
  input  wire [NCH*2-1:0] tx_char_control_i,
  // Outputs
  output reg  [NCH*8-1:0] char_o,
  output reg  [NCH*2-1:0] type_o,
  output reg  [NCH-1:0]   built_in_selftest_act_o,
  output reg  [NCH-1:0]   sync_act_o,
  output reg  [7:0]       selftest_latch_o
);
`include "tbc_map.vh"
  // =====================================================
  // Pin synchronisers, three stages
  localparam SW = 14;
  wire [SW-1:0] pin_w = {per_output_enable_bits_i, selftest_latch_enable_i,
                         rx_clock_source_select_mid_i,
                         tx_operating_select_hi_low_i, tx_atomic_sync_i,
                         rx_bonding_select_i};
  reg  [SW-1:0] s1_q;
  reg  [SW-1:0] s2_q;
  reg  [SW-1:0] s3_q;
  reg  [SW-1:0] pin_q;
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_q  <= {SW{1'b0}};
      s2_q  <= {SW{1'b0}};
      s3_q  <= {SW{1'b0}};
      pin_q <= {SW{1'b0}};
    end
    else
    begin
      s1_q <= pin_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change counts once stages two and three agree
      pin_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
    end
  end
  wire [7:0] boe_w    = pin_q[13:6];
  wire       le_w     = pin_q[5];
  wire       rxmid_w  = pin_q[4];
  wire       txlow_w  = pin_q[3];
  wire       atomic_w = pin_q[2];
  wire [1:0] bond_w   = pin_q[1:0];
  // =====================================================
  // Self-test enable latch
  reg [7:0] latch_q;
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      latch_q <= `TBC_LATCH_RST;
    else if (le_w)
      latch_q <= boe_w;
    // Held while latch enable low, value at its fall kept
  end
  // =====================================================
  // Character type selection
  reg [NCH*2-1:0] ctype_w;
  reg [NCH-1:0]   start_w;
  wire [1:0] ca = tx_char_control_i[1:0];
  wire [1:0] cb = tx_char_control_i[3:2];
  wire [1:0] cc = tx_char_control_i[5:4];
  wire [1:0] cd = tx_char_control_i[7:6];
  integer i;
  always @*
  begin
    ctype_w = tx_char_control_i;
    start_w = {NCH{1'b0}};
    for (i = 0; i < NCH; i = i + 1)
      start_w[i] = (tx_char_control_i[2*i+:2] == `TBC_TYPE_SYNC);
    if (bond_w == `TBC_BOND_DUAL)
    begin
      ctype_w[1:0] = ca;
      ctype_w[3:2] = {cb[1], ca[0]};
      ctype_w[5:4] = cc;
      ctype_w[7:6] = {cd[1], cc[0]};
      start_w[0] = cb[0] | (ca == `TBC_TYPE_SYNC);
      start_w[1] = cb[0] | (cb[1] & ca[0]);
      start_w[2] = cd[0] | (cc == `TBC_TYPE_SYNC);
      start_w[3] = cd[0] | (cd[1] & cc[0]);
      if (cb[0])
      begin
        ctype_w[3:0] = {`TBC_TYPE_SYNC, `TBC_TYPE_SYNC};
      end
      if (cd[0])
      begin
        ctype_w[7:4] = {`TBC_TYPE_SYNC, `TBC_TYPE_SYNC};
      end
    end
    else if (bond_w == `TBC_BOND_QUAD)
    begin
      for (i = 0; i < NCH; i = i + 1)
      begin
        // C and D low bits never read here
        ctype_w[2*i+:2] = {tx_char_control_i[2*i+1], ca[0]};
        start_w[i] = cb[0] | (tx_char_control_i[2*i+1] & ca[0]);
        if (cb[0])
          ctype_w[2*i+:2] = `TBC_TYPE_SYNC;
      end
    end
  end
  // =====================================================
  // Channels
  wire bsync_w = !rxmid_w && !txlow_w;
  wire [NCH*8-1:0] ch_char_w;
  wire [NCH*2-1:0] ch_type_w;
  wire [NCH-1:0]   ch_built_in_selftest_w;
  wire [NCH-1:0]   ch_sync_w;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      tbc_chan u_chan
      (
        .sys_clk_i    (sys_clk_i),
        .rst_n_i      (rst_n_i),
        .built_in_selftest_en_i    (!latch_q[2*g+1]),
        .built_in_selftest_sync_i  (bsync_w),
        .sync_start_i (start_w[g]),
        .atomic_i     (atomic_w | (bond_w != `TBC_BOND_NONE)),
        .type_i       (ctype_w[2*g+:2]),
        .data_i       (tx_char_data_i[8*g+:8]),
        .ctrl_i       (tx_char_control_i[2*g+:2]),
        .char_o       (ch_char_w[8*g+:8]),
        .type_o       (ch_type_w[2*g+:2]),
        .built_in_selftest_act_o   (ch_built_in_selftest_w[g]),
        .sync_act_o   (ch_sync_w[g])
      );
    end
  endgenerate
  // =====================================================
  // Registered outputs
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      char_o           <= {NCH*8{1'b0}};
      type_o           <= {NCH*2{1'b0}};
      built_in_selftest_act_o       <= {NCH{1'b0}};
      sync_act_o       <= {NCH{1'b0}};
      selftest_latch_o <= `TBC_LATCH_RST;
    end
    else
    begin
      char_o           <= ch_char_w;
      type_o           <= ch_type_w;
      built_in_selftest_act_o       <= ch_built_in_selftest_w;
      sync_act_o       <= ch_sync_w;
      selftest_latch_o <= latch_q;
    end
  end
endmodule
`default_nettype wire

// >>> tbc_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module tbc_top_bench;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  boe = 8'hff;
  logic        ble = 1'b0;
  logic [1:0]  bs = 2'h0;
  logic        atm = 1'b1;
  logic [7:0]  hc = 8'h00;
  logic [31:0] hd = 32'h0;
  wire logic [7:0]  ctl;
  wire logic [31:0] dat;
  wire logic [31:0] ch;
  wire logic [7:0]  ty;
  wire logic [3:0]  ba;
  wire logic [3:0]  sa;
  wire logic [7:0]  la;
  int          err_total = 0;
  int          n_compared = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  tbc_host host (.sys_clk_i(sys_clk_i), .ctl_i(hc), .dat_i(hd),
    .ctl_o(ctl), .dat_o(dat));
  tbc_top #(.NCH(4)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .per_output_enable_bits_i(boe), .selftest_latch_enable_i(ble),
    .rx_clock_source_select_mid_i(1'b0), .tx_operating_select_hi_low_i(1'b0),
    .tx_atomic_sync_i(atm), .rx_bonding_select_i(bs),
    .tx_char_data_i(dat), .tx_char_control_i(ctl), .char_o(ch), .type_o(ty),
    .built_in_selftest_act_o(ba), .sync_act_o(sa), .selftest_latch_o(la));
  // ==============================
  // Shared tasks
  task automatic close_out;
    $display("compared %0d bad %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] c, input logic [31:0] d);
    @(posedge sys_clk_i);
    hc = c;
    hd = d;
    @(negedge sys_clk_i);
  endtask
  // Bounded wait: a hang would hide every later check
  task automatic wait_on(input bit b, input int g);
    int k;
    for (k = 0; k < 300 && (b ? ba[g] : sa[g]) !== 1'b1; k++)
      @(negedge sys_clk_i);
    if (k == 300)
    begin
      err_total++;
      $display("BAD %0t wait ran out", $time);
      close_out;
    end
  endtask
  // ==============================
  // Scenarios
  task automatic t_sync;
    int n;
    put(8'h03, 32'h0);
    put(8'h00, 32'h0);
    wait_on(0, 0);
    for (n = 0; n < 40 && sa[0] === 1'b1; n++)
      @(negedge sys_clk_i);
    cmp(n, 16);
    $display("t_sync done");
  endtask
  task automatic t_dual;
    logic [1:0] k;
    logic [3:0] m;
    bs = 2'h1;
    repeat (6) @(negedge sys_clk_i);
    for (int i = 0; i < 3; i++)
    begin
      k = i[1:0];
      m = {k[1], 1'b0, k};
      put({m, m}, 32'hc3a5_5a3c);
      repeat (2) @(negedge sys_clk_i);
      cmp(ty, {4{k}});
      if (k == 2'h0)
        cmp(ch, 32'hc3a5_5a3c);
    end
    put(8'h44, 32'h0);
    put(8'h00, 32'h0);
    @(negedge sys_clk_i);
    cmp(sa, 4'hf);
    repeat (20) @(negedge sys_clk_i);
    $display("t_dual done");
  endtask
  task automatic t_quad;
    bs = 2'h2;
    repeat (6) @(negedge sys_clk_i);
    put(8'h70, 32'h0);
    repeat (2) @(negedge sys_clk_i);
    cmp(ty, 8'h20);
    put(8'h04, 32'h0);
    put(8'h00, 32'h0);
    @(negedge sys_clk_i);
    cmp(sa, 4'hf);
    repeat (20) @(negedge sys_clk_i);
    bs = 2'h0;
    $display("t_quad done");
  endtask
  task automatic t_intr;
    atm = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    put(8'h03, 32'h0);
    put(8'h00, 32'h0);
    put(8'h00, 32'h0);
    put(8'h02, 32'h0);
    cmp(sa[0], 1'b1);
    put(8'h00, 32'h0);
    @(negedge sys_clk_i);
    cmp(sa[0], 1'b0);
    cmp(ty[1:0], 2'h2);
    atm = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    $display("t_intr done");
  endtask
  task automatic t_built_in_selftest;
    put(8'h01, 32'h0);
    boe = 8'hfd;
    ble = 1'b1;
    wait_on(1, 0);
    wait_on(0, 0);
    ble = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    boe = 8'hff;
    repeat (6) @(negedge sys_clk_i);
    cmp(la, 8'hfd);
    cmp(ba, 4'h1);
    rst_n_i = 1'b0;
    @(negedge sys_clk_i);
    cmp(la, 8'hff);
    cmp(ba, 4'h0);
    rst_n_i = 1'b1;
    $display("t_built_in_selftest done");
  endtask
  initial
  begin
    repeat (5) @(negedge sys_clk_i);
    cmp(la, 8'hff);
    rst_n_i = 1'b1;
    t_sync;
    t_dual;
    t_quad;
    t_intr;
    t_built_in_selftest;
    close_out;
  end
endmodule
`default_nettype wire
